// ===== rtl/wtm_pkg.sv
// Purpose: constants and carriers for watchpoint trace messaging
// Assumes: APB, 32-bit data, one word per register except debug_ctl_one, which takes two
// Notes:   debug_ctl_one is 64 bits, split in two words
package wtm_pkg;
    localparam int        NUM_WP         = 15;
    localparam logic [11:0] ADDR_DC1_LO  = 12'h000;
    localparam logic [11:0] ADDR_DC1_HI  = 12'h004;
    localparam logic [11:0] ADDR_DC2     = 12'h008;
    localparam logic [11:0] ADDR_WATCH_MSG_MASK    = 12'h00C;
    localparam logic [11:0] ADDR_WT1     = 12'h010;
    localparam logic [11:0] ADDR_CFG     = 12'h014;
    localparam logic [11:0] ADDR_STAT    = 12'h018;
    // Bit 60 of 64-bit register lands at bit 28 of the high word
    localparam int        TM_WP_BIT      = 28;
    localparam int        EOC_LSB        = 0;
    localparam int        EOC_W          = 2;
    localparam int        EWC_W          = 5;
    localparam int        DEBUG_EVENT_OUT_W         = 5;
    localparam logic [5:0] TCODE_WATCH   = 6'h0F;
    localparam logic [1:0] EOC_OFF       = 2'h0;
    localparam logic [1:0] EOC_WATCH     = 2'h1;
    localparam logic [31:0] ZERO32       = 32'h0000_0000;
    // Interrupt taken, interrupt return and both event inputs need no setup
    localparam logic [14:0] CFG_FREE     = 15'h00CC;

    typedef struct packed {
        logic [5:0]  tcode;
        logic [14:0] hits;
    } wtm_msg_t;

    typedef struct packed {
        logic [14:0] start;
        logic [14:0] stop;
    } wtm_trig_t;
endpackage : wtm_pkg

// ===== rtl/wtm_watch.sv
// Purpose: collects watchpoint sources, builds watch messages, triggers
// Assumes: all core event inputs are single-cycle pulses on clk
// Notes:   registers on APB; one wait state; slverr on unmapped
`timescale 1ns/1ps
module wtm_watch (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        instrAddrCmp1,
    input  wire logic        instrAddrCmp2,
    input  wire logic        intTaken,
    input  wire logic        intReturn,
    input  wire logic        dataAddrCmp1,
    input  wire logic        dataAddrCmp2,
    input  wire logic        eventInputZero,
    input  wire logic        eventInputOne,
    input  wire logic        dataAcqEventZero,
    input  wire logic        dataAcqEventOne,
    input  wire logic        processIdentUpdate,
    input  wire logic        perfWatchZero,
    input  wire logic        perfWatchOne,
    input  wire logic        perfWatchTwo,
    input  wire logic        externalDebugMode,
    input  wire logic        extDebugStatusSet,
    input  wire logic        debugHalted,
    input  wire logic        debugStopped,
    input  wire logic        jamming,
    output wtm_pkg::wtm_msg_t msgData,
    output logic             msgValid,
    output logic [4:0]       debugEventOut,
    output logic             progTraceStart,
    output logic             progTraceStop
);
    logic [31:0] debugCtlOneLo;
    logic [31:0] debugCtlOneHi;
    logic [31:0] debugCtlTwo;
    logic [14:0] watchMsgMask;
    wtm_pkg::wtm_trig_t traceWatchTrigger;
    logic [14:0] srcConfigured;
    logic [14:0] rawHits;
    logic [14:0] maskedHits;
    logic [14:0] lastHits;
    logic        traceOn;
    logic        suppress;
    logic        busAccess;
    logic        mapped;

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Address and data compares and interrupt return fire directly, or in EXTERNAL_DEBUG_MODE only on the status update
    logic addrHalt;
    assign addrHalt = externalDebugMode & extDebugStatusSet;

    always_comb begin
        rawHits     = '0;
        rawHits[0]  = externalDebugMode ? (instrAddrCmp1 & addrHalt) : instrAddrCmp1;
        rawHits[1]  = externalDebugMode ? (instrAddrCmp2 & addrHalt) : instrAddrCmp2;
        rawHits[2]  = intTaken;
        rawHits[3]  = externalDebugMode ? (intReturn & addrHalt) : intReturn;
        rawHits[4]  = externalDebugMode ? (dataAddrCmp1 & addrHalt) : dataAddrCmp1;
        rawHits[5]  = externalDebugMode ? (dataAddrCmp2 & addrHalt) : dataAddrCmp2;
        rawHits[6]  = eventInputZero;
        rawHits[7]  = eventInputOne;
        rawHits[8]  = dataAcqEventZero;
        rawHits[9]  = dataAcqEventOne;
        rawHits[10] = processIdentUpdate;
        rawHits[11] = perfWatchZero;
        rawHits[12] = perfWatchOne;
        rawHits[13] = perfWatchTwo;
        rawHits[14] = 1'b0;
        rawHits     = rawHits & (srcConfigured | wtm_pkg::CFG_FREE);
    end

    assign suppress   = debugHalted | debugStopped | jamming;
    // Enable read live from the register, so leaving halt restores it at once
    assign traceOn    = debugCtlOneHi[wtm_pkg::TM_WP_BIT] & ~suppress;
    assign maskedHits = rawHits & watchMsgMask;

    assign busAccess = psel & penable;
    always_comb begin
        case (paddr)
            wtm_pkg::ADDR_DC1_LO, wtm_pkg::ADDR_DC1_HI, wtm_pkg::ADDR_DC2,
            wtm_pkg::ADDR_WATCH_MSG_MASK, wtm_pkg::ADDR_WT1, wtm_pkg::ADDR_CFG,
            wtm_pkg::ADDR_STAT: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
    end

    // Register writes; trace module reset clears all
    always_ff @(posedge clk) begin
        if (reset) begin
            debugCtlOneLo     <= wtm_pkg::ZERO32;
            debugCtlOneHi     <= wtm_pkg::ZERO32;
            debugCtlTwo       <= wtm_pkg::ZERO32;
            watchMsgMask      <= '0;
            traceWatchTrigger <= '0;
            srcConfigured     <= '0;
        end else if (busAccess && pwrite && !pready) begin
            case (paddr)
                wtm_pkg::ADDR_DC1_LO: debugCtlOneLo <= lane_merge(debugCtlOneLo, pwdata, pstrb);
                wtm_pkg::ADDR_DC1_HI: debugCtlOneHi <= lane_merge(debugCtlOneHi, pwdata, pstrb);
                wtm_pkg::ADDR_DC2:    debugCtlTwo   <= lane_merge(debugCtlTwo, pwdata, pstrb);
                wtm_pkg::ADDR_WATCH_MSG_MASK:   watchMsgMask  <= 15'(lane_merge({17'h0, watchMsgMask}, pwdata, pstrb));
                wtm_pkg::ADDR_WT1:    traceWatchTrigger <= 30'(lane_merge({2'h0, traceWatchTrigger},
                                                                        pwdata, pstrb));
                wtm_pkg::ADDR_CFG:    srcConfigured <= 15'(lane_merge({17'h0, srcConfigured}, pwdata, pstrb));
                default: ;
            endcase
        end
    end

    // APB answer: one wait state, pready pulses once per transfer
    always_ff @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= wtm_pkg::ZERO32;
        end else begin
            pready  <= busAccess & ~pready;
            pslverr <= busAccess & ~pready & ~mapped;
            prdata  <= wtm_pkg::ZERO32;
            if (busAccess && !pready && !pwrite) begin
                case (paddr)
                    wtm_pkg::ADDR_DC1_LO: prdata <= debugCtlOneLo;
                    wtm_pkg::ADDR_DC1_HI: prdata <= debugCtlOneHi;
                    wtm_pkg::ADDR_DC2:    prdata <= debugCtlTwo;
                    wtm_pkg::ADDR_WATCH_MSG_MASK:   prdata <= {17'h0, watchMsgMask};
                    wtm_pkg::ADDR_WT1:    prdata <= {2'h0, traceWatchTrigger};
                    wtm_pkg::ADDR_CFG:    prdata <= {17'h0, srcConfigured};
                    wtm_pkg::ADDR_STAT:   prdata <= {17'h0, lastHits};
                    default:              prdata <= wtm_pkg::ZERO32;
                endcase
            end
        end
    end

    // One message per cycle carrying every masked hit
    always_ff @(posedge clk) begin
        if (reset) begin
            msgValid <= 1'b0;
            msgData  <= '0;
            lastHits <= '0;
        end else begin
            msgValid <= traceOn & (|maskedHits);
            if (traceOn && |maskedHits) begin
                msgData.tcode <= wtm_pkg::TCODE_WATCH;
                msgData.hits  <= maskedHits;
                lastHits      <= maskedHits;
            end
        end
    end

    // Debug event outputs: each line picks its watchpoint number (0 = none)
    logic [4:0] next_evt;
    always_comb begin
        logic [4:0] sel;
        sel = '0;
        for (int k = 0; k < wtm_pkg::DEBUG_EVENT_OUT_W; k++) begin
            sel          = debugCtlTwo[k*wtm_pkg::EWC_W +: wtm_pkg::EWC_W];
            next_evt[k]  = 1'b0;
            if (sel != 5'h00 && sel <= 5'h0F) begin
                next_evt[k] = rawHits[4'(sel - 5'h01)];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            debugEventOut <= '0;
        end else if (debugCtlOneLo[wtm_pkg::EOC_LSB +: wtm_pkg::EOC_W] == wtm_pkg::EOC_WATCH) begin
            debugEventOut <= next_evt;
        end else begin
            debugEventOut <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            progTraceStart <= 1'b0;
            progTraceStop  <= 1'b0;
        end else begin
            progTraceStart <= |(rawHits & traceWatchTrigger.start);
            progTraceStop  <= |(rawHits & traceWatchTrigger.stop);
        end
    end

    // Assertions
    msg_on_hit_a: assert property (@(posedge clk) disable iff (reset)
        (traceOn && |maskedHits) |=> msgValid && msgData.hits == $past(maskedHits))
        else $error("message missing or wrong hits");
    no_msg_halt_a: assert property (@(posedge clk) disable iff (reset)
        $past(suppress) |-> !msgValid)
        else $error("message while halted");
    mask_filter_a: assert property (@(posedge clk) disable iff (reset)
        msgValid |-> (msgData.hits & ~$past(watchMsgMask)) == 15'h0)
        else $error("unmasked bit in hits");
    wp15_zero_a: assert property (@(posedge clk) disable iff (reset)
        msgValid |-> !msgData.hits[14])
        else $error("reserved watchpoint fired");
    event_input_zero_hit_a: assert property (@(posedge clk) disable iff (reset)
        (eventInputZero && watchMsgMask[6] && traceOn) |=> msgValid && msgData.hits[6])
        else $error("event input zero lost");
    empty_mask_a: assert property (@(posedge clk) disable iff (reset)
        (watchMsgMask == 15'h0) |=> !msgValid)
        else $error("message with empty mask");
    en_off_a: assert property (@(posedge clk) disable iff (reset)
        !debugCtlOneHi[wtm_pkg::TM_WP_BIT] |=> !msgValid)
        else $error("message while disabled");
    reset_clear_a: assert property (@(posedge clk)
        reset |=> watchMsgMask == 15'h0 && debugCtlOneHi == 32'h0)
        else $error("reset left config");
    pready_one_a: assert property (@(posedge clk) disable iff (reset)
        pready |=> !pready)
        else $error("pready held");
    debug_event_out_gate_a: assert property (@(posedge clk) disable iff (reset)
        (debugCtlOneLo[wtm_pkg::EOC_LSB +: wtm_pkg::EOC_W] != wtm_pkg::EOC_WATCH) |=> debugEventOut == 5'h00)
        else $error("event out while disabled");
    trig_start_a: assert property (@(posedge clk) disable iff (reset)
        (|(rawHits & traceWatchTrigger.start)) |=> progTraceStart)
        else $error("trace start trigger lost");

    multi_hit_c: cover property (@(posedge clk) disable iff (reset) msgValid && !$onehot(msgData.hits));
    halt_exit_c: cover property (@(posedge clk) disable iff (reset) $fell(debugHalted) ##1 msgValid);
    debug_event_out_c:      cover property (@(posedge clk) disable iff (reset) |debugEventOut);
    trig_c:      cover property (@(posedge clk) disable iff (reset) progTraceStart);
endmodule : wtm_watch

// ===== verif/wtm_msg_sink.sv
// Purpose: stand-in for the trace message queue at the far side
// Assumes: queue always accepts, so no back-pressure is modelled
// Notes:   counts messages; a double pulse shows up as an extra count
`timescale 1ns/1ps
module wtm_msg_sink (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              msgValid,
    input  wire wtm_pkg::wtm_msg_t msgData,
    output logic [31:0]            msgCount,
    output wtm_pkg::wtm_msg_t      lastMsg
);
    always_ff @(posedge clk) begin
        if (reset) begin
            msgCount <= 32'h0000_0000;
        end else if (msgValid) begin
            msgCount <= msgCount + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (msgValid) begin
            lastMsg <= msgData;
        end
    end
endmodule : wtm_msg_sink

// ===== verif/test_watchpoint_trace_messaging.sv
// Purpose: self-checking bench for watchpoint trace messaging
// Assumes: one APB wait state, one-cycle output pulses
// Notes:   control levels are applied only during the event cycle
`timescale 1ns/1ps
module test_watchpoint_trace_messaging;
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic [11:0]       paddr = 12'h000;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              msgValid;
    logic              progTraceStart;
    logic              progTraceStop;
    logic [4:0]        debugEventOut;
    wtm_pkg::wtm_msg_t msgData;
    logic [13:0]       ev = 14'h0000;
    logic [4:0]        ctl = 5'h00;
    logic [31:0]       msgCount;
    logic [31:0]       cnt0;
    logic [31:0]       rd;
    logic              err;
    logic [6:0]        side;
    int                mismatches = 0;
    int                comparisons = 0;

    always #2 clk = ~clk;

    wtm_watch wtm_watch_inst (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instrAddrCmp1(ev[0]), .instrAddrCmp2(ev[1]), .intTaken(ev[2]), .intReturn(ev[3]),
        .dataAddrCmp1(ev[4]), .dataAddrCmp2(ev[5]), .eventInputZero(ev[6]), .eventInputOne(ev[7]),
        .dataAcqEventZero(ev[8]), .dataAcqEventOne(ev[9]), .processIdentUpdate(ev[10]),
        .perfWatchZero(ev[11]), .perfWatchOne(ev[12]), .perfWatchTwo(ev[13]),
        .externalDebugMode(ctl[0]), .extDebugStatusSet(ctl[1]), .debugHalted(ctl[2]),
        .debugStopped(ctl[3]), .jamming(ctl[4]), .msgData(msgData), .msgValid(msgValid),
        .debugEventOut(debugEventOut), .progTraceStart(progTraceStart), .progTraceStop(progTraceStop));

    wtm_msg_sink wtm_msg_sink_inst (.clk(clk), .reset(reset), .msgValid(msgValid), .msgData(msgData),
        .msgCount(msgCount), .lastMsg());

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One event cycle, then message and side outputs are checked a cycle later
    task automatic fire(input logic [13:0] v, input logic [4:0] c, input logic [14:0] exp);
        cnt0 = msgCount;
        @(posedge clk);
        ev  <= v;
        ctl <= c;
        @(posedge clk);
        ev  <= 14'h0000;
        ctl <= 5'h00;
        #1;
        side = {debugEventOut, progTraceStart, progTraceStop};
        chk({31'h0, msgValid}, {31'h0, exp != 15'h0000});
        if (exp != 15'h0000) chk(32'(msgData), {11'h000, wtm_pkg::TCODE_WATCH, exp});
        @(posedge clk);
        #1;
        chk(msgCount - cnt0, {31'h0, exp != 15'h0000});
    endtask : fire

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        #20000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({26'h0, debugEventOut, msgValid}, 32'h0000_0000);
        apb(1'b0, wtm_pkg::ADDR_DC1_HI, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, wtm_pkg::ADDR_DC1_HI, 32'h1000_0000);
        apb(1'b1, wtm_pkg::ADDR_WATCH_MSG_MASK, 32'h0000_7FFF);
        apb(1'b1, wtm_pkg::ADDR_CFG, 32'h0000_7FFF);
        for (int k = 0; k < 14; k++) fire(14'(1 << k), 5'h00, 15'(1 << k));
        fire(14'h3FFF, 5'h00, 15'h3FFF);
        apb(1'b1, wtm_pkg::ADDR_WATCH_MSG_MASK, 32'h0000_4055);
        fire(14'h3FFF, 5'h00, 15'h0055);
        apb(1'b1, wtm_pkg::ADDR_WATCH_MSG_MASK, 32'h0000_0000);
        fire(14'h3FFF, 5'h00, 15'h0000);
        apb(1'b1, wtm_pkg::ADDR_WATCH_MSG_MASK, 32'h0000_7FFF);
        apb(1'b1, wtm_pkg::ADDR_CFG, 32'h0000_0000);
        fire(14'h3FFF, 5'h00, 15'h00CC);
        apb(1'b1, wtm_pkg::ADDR_CFG, 32'h0000_7FFF);
        for (int s = 2; s < 5; s++) fire(14'h3FFF, 5'(1 << s), 15'h0000);
        fire(14'h0001, 5'h00, 15'h0001);
        fire(14'h0001, 5'h01, 15'h0000);
        fire(14'h0001, 5'h03, 15'h0001);
        fire(14'h0004, 5'h01, 15'h0004);
        apb(1'b1, wtm_pkg::ADDR_DC1_HI, 32'h0000_0000);
        apb(1'b1, wtm_pkg::ADDR_DC1_LO, 32'h0000_0001);
        apb(1'b1, wtm_pkg::ADDR_DC2, 32'h0070_0000);
        fire(14'h0040, 5'h00, 15'h0000);
        chk({25'h0, side}, 32'h0000_0040);
        apb(1'b1, wtm_pkg::ADDR_DC1_LO, 32'h0000_0000);
        fire(14'h0040, 5'h00, 15'h0000);
        chk({25'h0, side}, 32'h0000_0000);
        apb(1'b1, wtm_pkg::ADDR_WT1, 32'h0040_0001);
        fire(14'h0080, 5'h00, 15'h0000);
        chk({25'h0, side}, 32'h0000_0002);
        fire(14'h0001, 5'h00, 15'h0000);
        chk({25'h0, side}, 32'h0000_0001);
        apb(1'b0, wtm_pkg::ADDR_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b0, 12'h01C, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, wtm_pkg::ADDR_WT1, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, wtm_pkg::ADDR_WATCH_MSG_MASK, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : test_watchpoint_trace_messaging
